// ---- src/strap_boot_defs.vh ----
// Constants for the reset strap capture, host map decode and boot select block.
`ifndef STRAP_BOOT_DEFS_VH
`define STRAP_BOOT_DEFS_VH
`define STRAP_W            8
`define STRAP_RESET        8'h01
`define BIT_NV_HI          7
`define BIT_NV_LO          6
`define BIT_ISA_MODE       5
`define BIT_IO_DECODE      4
`define BIT_ROM_DISABLE    0
`define IO_OFS_COR         8'h40
`define IO_OFS_CSR         8'h42
`define IO_OFS_PRR         8'h44
`define REG_SEL_NONE       2'h0
`define REG_SEL_COR        2'h1
`define REG_SEL_CSR        2'h2
`define REG_SEL_PRR        2'h3
`define ADDR_STRAPS        4'h0
`define ADDR_BOOT_STATUS   4'h1
`define ADDR_BOOT_CTRL     4'h2
`define ADDR_BOOT_DATA     4'h3
`define ADDR_BOOT_ADDR     4'h4
`define CLK_HZ             125000000
`define SER_HZ             400000
`define SER_HALF_CYCLES    ((`CLK_HZ / `SER_HZ) / 2)
`define SER_CNT_W          8
`define BOOT_IDLE          3'h0
`define BOOT_LARGE         3'h1
`define BOOT_SMALL         3'h2
`define BOOT_WAIT_HOST     3'h3
`define BOOT_UNSUPPORTED   3'h4
`define BOOT_DONE          3'h5
`define BOOT_LEN_LARGE     16'h0400
`define BOOT_LEN_SMALL     16'h0100
`endif

// ---- src/serial_clock_gen.v ----
// Serial boot port clock generator running the nonvolatile device clock at 400 kHz.
`timescale 1ns/1ps
`default_nettype none
`include "strap_boot_defs.vh"
module serial_clock_gen (
    input  wire       mclk,
    input  wire       nrst,
    input  wire       run,
    output reg        sclk,
    output reg        rise,
    output reg        fall
);
    reg [`SER_CNT_W-1:0] count;
    always @(posedge mclk) begin
        if (!nrst) begin
            count <= {`SER_CNT_W{1'b0}};
            sclk  <= 1'b0;
            rise  <= 1'b0;
            fall  <= 1'b0;
        end else if (!run) begin
            count <= {`SER_CNT_W{1'b0}};
            sclk  <= 1'b0;
            rise  <= 1'b0;
            fall  <= 1'b0;
        end else if (count == `SER_HALF_CYCLES - 1) begin // see (R10)
            count <= {`SER_CNT_W{1'b0}};
            sclk  <= ~sclk;
            rise  <= ~sclk;
            fall  <= sclk;
        end else begin
            count <= count + 1'b1;
            rise  <= 1'b0;
            fall  <= 1'b0;
        end
    end
endmodule // serial_clock_gen
`default_nettype wire

// ---- src/host_map_decode.v ----
// Host address decode for the card configuration registers in I/O and attribute space.
`timescale 1ns/1ps
`default_nettype none
`include "strap_boot_defs.vh"
module host_map_decode (
    input  wire       io_decode_eff,
    input  wire       isa_eff,
    input  wire       host_io,
    input  wire       host_attr,
    input  wire [7:0] host_addr,
    output reg  [1:0] reg_sel
);
    reg [1:0] by_addr;
    always @* begin
        case (host_addr)
            `IO_OFS_COR: by_addr = `REG_SEL_COR;
            `IO_OFS_CSR: by_addr = `REG_SEL_CSR;
            `IO_OFS_PRR: by_addr = `REG_SEL_PRR;
            default:     by_addr = `REG_SEL_NONE;
        endcase
        reg_sel = `REG_SEL_NONE;
        if (host_io && io_decode_eff) begin // see (R02) see (R03)
            reg_sel = by_addr;
        end else if (host_attr && !isa_eff) begin // see (R11)
            reg_sel = by_addr;
        end
    end
endmodule // host_map_decode
`default_nettype wire

// ---- src/reset_strap_host_map_boot_select.v ----
// Top level: strap capture at reset, host map selection and serial boot device control.
// Summary of operation
// (R01) Capture upper memory data straps while reset is active; use as startup configuration.
// (R02) I/O decode strap set maps option, status, pin registers at I/O 0x40, 0x42, 0x44.
// (R03) I/O decode strap clear decodes those registers only in attribute space.
// (R04) The I/O decode strap is ignored while the parallel host enable is low.
// (R05) ISA host mode forces the I/O decode strap high.
// (R06) Boards should strap I/O decoding high for PC Card use without ISA mode.
// (R07) Type straps 00 load firmware from a large serial part into external SRAM.
// (R08) Type straps 01 load only card information, then idle waiting for the host.
// (R09) Upper type strap high means unsupported; no serial device type is defined.
// (R10) The serial boot port runs at 400 kHz.
// (R11) ISA mode puts all registers in I/O space, disables attribute space, needs host enable.
// (R12) Strap bits 3 to 0 have no effect on configuration.
`timescale 1ns/1ps
`default_nettype none
`include "strap_boot_defs.vh"
module reset_strap_host_map_boot_select (
    input  wire        mclk,
    input  wire        nrst,
    input  wire        soft_reset,
    input  wire [7:0]  upper_memdata_straps,
    input  wire        parallel_host_enable,
    input  wire        host_io,
    input  wire        host_attr,
    input  wire [7:0]  host_addr,
    input  wire        nv_miso,
    input  wire        host_start,
    input  wire [3:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,
    output reg         io_decode_active,
    output reg         attr_space_enable,
    output reg  [1:0]  cfg_reg_sel,
    output reg         nv_sclk,
    output reg         nv_cs_n,
    output reg         sram_we,
    output reg  [15:0] sram_addr,
    output reg  [7:0]  sram_data,
    output reg         boot_busy,
    output reg         boot_unsupported,
    output reg         boot_waiting_host
);
    // Straps are sampled continuously while any reset holds, so the last level before release is kept.
    reg  [`STRAP_W-1:0] straps;
    reg  [2:0]          state;
    reg  [2:0]          next_state;
    reg  [15:0]         byte_count;
    reg  [15:0]         boot_len;
    reg  [2:0]          bit_count;
    reg  [7:0]          shift;
    reg                 ser_run;
    reg                 start_pending;
    reg                 host_release;
    wire                sclk_w;
    wire                rise_w;
    wire                fall_w;
    wire [1:0]          sel_w;
    wire                nv_hi   = straps[`BIT_NV_HI];
    wire                nv_lo   = straps[`BIT_NV_LO];
    wire                isa_eff = straps[`BIT_ISA_MODE] & parallel_host_enable;               // see (R11)
    wire                io_eff  = parallel_host_enable &
                                  (straps[`BIT_IO_DECODE] | straps[`BIT_ISA_MODE]);         // see (R04) see (R05)
    wire                in_reset = !nrst || soft_reset;

    always @(posedge mclk) begin
        if (!nrst) begin
            straps <= upper_memdata_straps & 8'hF0;                                           // see (R01) see (R12)
        end else if (soft_reset) begin
            straps <= upper_memdata_straps & 8'hF0;                                           // see (R01) see (R12)
        end
    end

    host_map_decode u_map (
        .io_decode_eff (io_eff),
        .isa_eff       (isa_eff),
        .host_io       (host_io),
        .host_attr     (host_attr),
        .host_addr     (host_addr),
        .reg_sel       (sel_w)
    );

    serial_clock_gen u_sclk (
        .mclk (mclk),
        .nrst (nrst),
        .run  (ser_run),
        .sclk (sclk_w),
        .rise (rise_w),
        .fall (fall_w)
    );

    always @* begin
        next_state = state;
        case (state)
            `BOOT_IDLE: begin
                if (nv_hi) begin
                    next_state = `BOOT_UNSUPPORTED;                                           // see (R09)
                end else if (!nv_lo) begin
                    next_state = `BOOT_LARGE;                                                 // see (R07)
                end else begin
                    next_state = `BOOT_SMALL;                                                 // see (R08)
                end
            end
            `BOOT_LARGE: begin
                if (rise_w && bit_count == 3'h7 && byte_count == boot_len - 16'h0001) begin
                    next_state = `BOOT_DONE;
                end
            end
            `BOOT_SMALL: begin
                if (rise_w && bit_count == 3'h7 && byte_count == boot_len - 16'h0001) begin
                    next_state = `BOOT_WAIT_HOST;                                             // see (R08)
                end
            end
            `BOOT_WAIT_HOST: begin
                if (start_pending) begin
                    next_state = `BOOT_DONE;
                end
            end
            `BOOT_UNSUPPORTED: next_state = `BOOT_UNSUPPORTED;
            `BOOT_DONE:        next_state = `BOOT_DONE;
            default:           next_state = `BOOT_IDLE;
        endcase
    end

    always @(posedge mclk) begin
        if (in_reset) begin
            state         <= `BOOT_IDLE;
            byte_count    <= 16'h0000;
            boot_len      <= `BOOT_LEN_SMALL;
            bit_count     <= 3'h0;
            shift         <= 8'h00;
            ser_run       <= 1'b0;
            start_pending <= 1'b0;
            host_release  <= 1'b0;
            sram_we       <= 1'b0;
            sram_addr     <= 16'h0000;
            sram_data     <= 8'h00;
            nv_cs_n       <= 1'b1;
        end else begin
            state   <= next_state;
            sram_we <= 1'b0;
            // A start request arriving while the port still loads is remembered, so it is not lost.
            if (host_start || (reg_wr && reg_addr == `ADDR_BOOT_CTRL && reg_wdata[0])) begin
                start_pending <= 1'b1;
            end else if (state == `BOOT_DONE) begin
                start_pending <= 1'b0;
            end
            if (state == `BOOT_WAIT_HOST && start_pending) begin
                host_release <= 1'b1;
            end
            if (state == `BOOT_IDLE && !nv_hi) begin
                boot_len <= nv_lo ? `BOOT_LEN_SMALL : `BOOT_LEN_LARGE;
                ser_run  <= 1'b1;
                nv_cs_n  <= 1'b0;
            end
            if ((state == `BOOT_LARGE || state == `BOOT_SMALL) && rise_w) begin
                shift     <= {shift[6:0], nv_miso};
                bit_count <= bit_count + 3'h1;
                if (bit_count == 3'h7) begin
                    byte_count <= byte_count + 16'h0001;
                    sram_data  <= {shift[6:0], nv_miso};
                    sram_addr  <= byte_count;
                    sram_we    <= (state == `BOOT_LARGE);                                    // see (R07)
                end
            end
            if (next_state == `BOOT_DONE || next_state == `BOOT_WAIT_HOST) begin
                ser_run <= 1'b0;
                nv_cs_n <= 1'b1;
            end
        end
    end

    always @(posedge mclk) begin
        if (!nrst) begin
            io_decode_active  <= 1'b0;
            attr_space_enable <= 1'b1;
            cfg_reg_sel       <= `REG_SEL_NONE;
            nv_sclk           <= 1'b0;
            boot_busy         <= 1'b0;
            boot_unsupported  <= 1'b0;
            boot_waiting_host <= 1'b0;
            reg_rdata         <= 16'h0000;
        end else begin
            io_decode_active  <= io_eff;                                                      // see (R02)
            attr_space_enable <= !isa_eff;                                                    // see (R11)
            cfg_reg_sel       <= sel_w;                                                       // see (R03)
            // The serial clock is gated by ser_run, so it drops one mclk cycle after the chip select is released.
            nv_sclk           <= sclk_w & ser_run;                                            // see (R10)
            boot_busy         <= (state == `BOOT_LARGE) || (state == `BOOT_SMALL);
            boot_unsupported  <= (state == `BOOT_UNSUPPORTED);                                // see (R09)
            boot_waiting_host <= (state == `BOOT_WAIT_HOST);
            reg_rdata         <= 16'h0000;
            if (reg_rd) begin
                case (reg_addr)
                    `ADDR_STRAPS:      reg_rdata <= {8'h00, straps};
                    `ADDR_BOOT_STATUS: reg_rdata <= {9'h000, host_release, io_eff, isa_eff,
                                                     state == `BOOT_WAIT_HOST, state};
                    `ADDR_BOOT_CTRL:   reg_rdata <= {15'h0000, start_pending};
                    `ADDR_BOOT_DATA:   reg_rdata <= {8'h00, shift};
                    `ADDR_BOOT_ADDR:   reg_rdata <= byte_count;
                    default:           reg_rdata <= 16'h0000;
                endcase
            end
        end
    end
endmodule // reset_strap_host_map_boot_select
`default_nettype wire

// ---- tb/strap_boot_properties.sv ----
// Checker for strap decode, host map selection and serial boot clock timing.
`timescale 1ns/1ps
`default_nettype none
`include "strap_boot_defs.vh"
module strap_boot_properties (
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic        soft_reset,
    input wire logic        parallel_host_enable,
    input wire logic        host_io,
    input wire logic        host_attr,
    input wire logic [7:0]  host_addr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        io_decode_active,
    input wire logic        attr_space_enable,
    input wire logic [1:0]  cfg_reg_sel,
    input wire logic        nv_sclk,
    input wire logic        nv_cs_n,
    input wire logic        sram_we,
    input wire logic        boot_unsupported
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // The first half period after a start or soft reset has no known origin, so it is not measured.
    logic       prev;
    logic [8:0] run;
    logic       seen;
    always @(posedge mclk) begin
        prev <= nv_sclk;
        if (!nrst || nv_cs_n || soft_reset) begin
            run <= 9'h001;
            seen <= 1'b0;
        end else if (nv_sclk != prev) begin
            run <= 9'h001;
            seen <= 1'b1;
        end else begin
            run <= run + 9'h001;
        end
    end
    AST_SCLK_HALF: assert property (seen && !nv_cs_n && nv_sclk != prev |-> run == 9'h09C)
        else $error("serial clock half period wrong");
    AST_SCLK_IDLE: assert property (nv_cs_n[*2] |-> !nv_sclk)
        else $error("serial clock runs while deselected");
    AST_PHE_OFF_IO: assert property (!parallel_host_enable[*2] |-> !io_decode_active)
        else $error("io decode active without host enable");
    AST_PHE_OFF_ATTR: assert property (!parallel_host_enable[*2] |-> attr_space_enable)
        else $error("attribute space off without host enable");
    AST_ISA_FORCES_IO: assert property (!attr_space_enable |-> io_decode_active)
        else $error("isa mode without io decode");
    AST_SEL_COR: assert property (host_io && !host_attr && io_decode_active && $stable(io_decode_active)
        && host_addr == `IO_OFS_COR |=> cfg_reg_sel == `REG_SEL_COR)
        else $error("option register not selected");
    AST_SEL_PRR: assert property (host_io && !host_attr && io_decode_active && $stable(io_decode_active)
        && host_addr == `IO_OFS_PRR |=> cfg_reg_sel == `REG_SEL_PRR)
        else $error("pin register not selected");
    AST_SEL_NONE: assert property (host_io && !host_attr && !io_decode_active && $stable(io_decode_active)
        |=> cfg_reg_sel == `REG_SEL_NONE)
        else $error("io select while io decode off");
    AST_SEL_ATTR_ISA: assert property (host_attr && !host_io && !attr_space_enable
        && $stable(attr_space_enable) |=> cfg_reg_sel == `REG_SEL_NONE)
        else $error("attribute select while isa mode");
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside read answer");
    AST_UNSUP_QUIET: assert property (boot_unsupported |-> nv_cs_n && !sram_we)
        else $error("serial bus used in unsupported mode");
    cover property (!attr_space_enable);
    cover property ($rose(nv_sclk));
    cover property (boot_unsupported);
    cover property (cfg_reg_sel == `REG_SEL_PRR);
endmodule // strap_boot_properties
bind reset_strap_host_map_boot_select strap_boot_properties u_props (.mclk, .nrst, .soft_reset,
    .parallel_host_enable, .host_io, .host_attr, .host_addr, .reg_rd, .reg_rdata, .io_decode_active,
    .attr_space_enable, .cfg_reg_sel, .nv_sclk, .nv_cs_n, .sram_we, .boot_unsupported);
`default_nettype wire

// ---- tb/serial_nv_model.sv ----
// Serial boot memory model shifting a byte pattern out most significant bit first.
`timescale 1ns/1ps
`default_nettype none
module serial_nv_model (
    input  wire logic mclk,
    input  wire logic nv_sclk,
    input  wire logic nv_cs_n,
    output var  logic nv_miso
);
    logic [7:0] pat = 8'hA5;
    logic [2:0] bitn = 3'h7;
    logic       last = 1'b0;
    logic       first = 1'b1;
    initial nv_miso = 1'b0;
    always @(posedge mclk) begin
        last <= nv_sclk;
        if (nv_cs_n) begin
            // The line has no pull, so a deselected part shows a changing value, never a stale bit.
            nv_miso <= ~nv_miso;
            bitn <= 3'h7;
            first <= 1'b1;
        end else if (first || (last && !nv_sclk)) begin
            // The leading bit stands from select on, because the block samples on the first rising edge.
            nv_miso <= pat[bitn];
            bitn <= bitn - 3'h1;
            first <= 1'b0;
            if (bitn == 3'h0) pat <= pat + 8'h3C;
        end
    end
endmodule // serial_nv_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for strap capture, host map decode and boot selection.
`timescale 1ns/1ps
`default_nettype none
`include "strap_boot_defs.vh"
module tb_top;
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic        soft_reset = 1'b0;
    logic        phe = 1'b0;
    logic        host_io = 1'b0;
    logic        host_attr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        reg_wr = 1'b0;
    logic        eio;
    logic        nv_miso;
    logic [7:0]  straps = 8'h00;
    logic [7:0]  host_addr = 8'h00;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] rdata;
    logic [15:0] reg_rdata;
    logic [1:0]  cfg_reg_sel;
    logic        io_decode_active, attr_space_enable, nv_sclk, nv_cs_n, boot_busy, boot_unsupported;
    logic        sram_we, boot_waiting_host;
    logic [7:0]  sram_data;
    logic [15:0] sram_addr, want;
    integer      errors = 0;
    integer      num_checks = 0;
    integer      i, k;
    always #4 mclk = ~mclk;
    reset_strap_host_map_boot_select dut (.mclk, .nrst, .soft_reset, .upper_memdata_straps(straps),
        .parallel_host_enable(phe), .host_io, .host_attr, .host_addr, .nv_miso, .host_start(1'b0),
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .io_decode_active, .attr_space_enable,
        .cfg_reg_sel, .nv_sclk, .nv_cs_n, .sram_we, .sram_addr, .sram_data, .boot_busy,
        .boot_unsupported, .boot_waiting_host);
    serial_nv_model nv (.mclk, .nv_sclk, .nv_cs_n, .nv_miso);
    task automatic results;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rdata = reg_rdata;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic boot(input logic [7:0] s, input logic p);
        @(posedge mclk);
        nrst <= 1'b0;
        host_io <= 1'b0;
        host_attr <= 1'b0;
        straps <= s;
        phe <= p;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    task automatic hio(input logic [7:0] a, input logic at, input logic [1:0] e);
        @(posedge mclk);
        host_io <= !at;
        host_attr <= at;
        host_addr <= a;
        @(posedge mclk);
        #1 chk({14'h0000, cfg_reg_sel}, {14'h0000, e});
    endtask
    initial begin
        for (i = 0; i < 8; i = i + 1) begin
            // The low nibble changes every pass; outputs must not follow it.
            boot({2'b10, i[1], i[0], i[3:0] ^ 4'h9}, i[2]);
            eio = i[2] & (i[1] | i[0]);
            chk({15'h0000, io_decode_active}, {15'h0000, eio});
            chk({15'h0000, attr_space_enable}, {15'h0000, ~(i[2] & i[1])});
            hio(`IO_OFS_COR, 1'b0, eio ? `REG_SEL_COR : `REG_SEL_NONE);
            hio(`IO_OFS_CSR, 1'b0, eio ? `REG_SEL_CSR : `REG_SEL_NONE);
            hio(`IO_OFS_PRR, 1'b0, eio ? `REG_SEL_PRR : `REG_SEL_NONE);
            hio(8'h46, 1'b0, `REG_SEL_NONE);
            hio(`IO_OFS_PRR, 1'b1, (i[2] & i[1]) ? `REG_SEL_NONE : `REG_SEL_PRR);
            rd(`ADDR_STRAPS);
            chk(rdata, {8'h00, straps[7:4], 4'h0});
        end
        wr(`ADDR_STRAPS, 16'hFFFF);
        rd(`ADDR_STRAPS);
        chk(rdata, {8'h00, straps[7:4], 4'h0});
        rd(4'hF);
        chk(rdata, 16'h0000);
        for (i = 0; i < 4; i = i + 1) begin
            boot({i[1:0], 6'h00}, 1'b1);
            for (k = 0; k < 40 && !(boot_busy | boot_unsupported); k = k + 1) @(posedge mclk);
            if (k == 40) begin
                errors = errors + 1;
                results();
            end
            rd(`ADDR_BOOT_STATUS);
            want = {13'h0000, i[1] ? `BOOT_UNSUPPORTED : (i[0] ? `BOOT_SMALL : `BOOT_LARGE)};
            chk({13'h0000, rdata[2:0]}, want);
            want = {12'h000, ~i[1], 1'b0, i[1], i[1]};
            chk({12'h000, boot_busy, boot_waiting_host, boot_unsupported, nv_cs_n}, want);
        end
        // A large boot runs until its first byte is written out, then a soft reset resamples the straps.
        boot(8'h00, 1'b1);
        for (k = 0; k < 3000 && sram_we !== 1'b1; k = k + 1) begin
            @(posedge mclk);
            #1;
        end
        if (k == 3000) begin
            errors = errors + 1;
            results();
        end
        chk({8'h00, sram_data}, 16'h00A5);
        chk(sram_addr, 16'h0000);
        rd(`ADDR_BOOT_DATA);
        chk(rdata, 16'h00A5);
        rd(`ADDR_BOOT_ADDR);
        chk(rdata, 16'h0001);
        @(posedge mclk);
        straps <= 8'h80;
        soft_reset <= 1'b1;
        repeat (2) @(posedge mclk);
        soft_reset <= 1'b0;
        repeat (10) @(posedge mclk);
        #1 chk({14'h0000, boot_unsupported, nv_cs_n}, 16'h0003);
        results();
    end
endmodule // tb_top
`default_nettype wire
